// ===== verilog/csl_map.svh
`ifndef CSL_MAP_SVH
`define CSL_MAP_SVH
// ==========================================
// timing
`define CSL_CLK_NS 5
`define CSL_PERIOD0_MS 16000
`define CSL_FAST_US 15500
// ==========================================
// register addresses
`define CSL_A_TEMP_LOC 8'h00
`define CSL_A_TEMP_R1H 8'h01
`define CSL_A_TEMP_R1L 8'h10
`define CSL_A_TEMP_R2H 8'h30
`define CSL_A_TEMP_R2L 8'h33
`define CSL_A_STAT1 8'h02
`define CSL_A_STAT2 8'h23
`define CSL_A_CFG_RD 8'h03
`define CSL_A_CFG_WR 8'h09
`define CSL_A_RATE_RD 8'h04
`define CSL_A_RATE_WR 8'h0a
`define CSL_A_HYST 8'h21
// limit window: addr[7:5] tag, addr[4:3] channel, addr[2:0] field
`define CSL_LIM_TAG 3'b010
`define CSL_LIM_FLD_N 3'd5
`define CSL_LIM_HI_H 3'd0
`define CSL_LIM_HI_L 3'd1
`define CSL_LIM_LO_H 3'd2
`define CSL_LIM_LO_L 3'd3
`define CSL_LIM_TH 3'd4
// ==========================================
// fields and reset values
`define CSL_RATE_RST 8'h08
`define CSL_RATE_AVG_DIS 7
`define CSL_RATE_CONT 4'hb
`define CSL_RATE_FAST 4'ha
`define CSL_RATE_NOAVG 4'h9
`define CSL_SEL_ALL 2'b00
`define CSL_SEL_LOC 2'b01
`define CSL_CFG_RST 8'h00
`define CSL_CFG_MASK 7
`define CSL_CFG_SHARED 5
`define CSL_CFG_R2VIEW 3
`define CSL_CFG_EXT 2
`define CSL_CFG_MASK_R1 1
`define CSL_CFG_MASK_R2 0
`define CSL_HYST_RST 8'h0a
`define CSL_HI_RST 8'h55
`define CSL_LO_RST 8'h00
`define CSL_TH_RST 8'h55
// arbitrary bus address
`define CSL_SLAVE_ADDR 7'h2a
`endif

// ===== verilog/csl_pkg.sv
package csl_pkg;
  typedef enum logic [2:0] {
    L_IDLE = 3'b000,
    L_ADDR = 3'b001,
    L_AACK = 3'b011,
    L_WBYTE = 3'b010,
    L_WACK = 3'b110,
    L_RBYTE = 3'b111,
    L_RACK = 3'b101
  } csl_link_state_t;

  typedef enum logic [1:0] {
    S_WAIT = 2'b00,
    S_START = 2'b01,
    S_CONV = 2'b11
  } csl_seq_state_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csl_req_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } csl_meas_t;

  typedef struct packed {
    csl_link_state_t st;
    logic scl_p;
    logic sda_p;
    logic [2:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic ackon;
    logic first;
    logic sda_oe;
    logic req_t;
    csl_req_t req;
    logic ack_p;
    logic [7:0] rdata;
  } csl_link_reg_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [7:0] hyst;
    logic [2:0][4:0][7:0] lim;
    logic [2:0][7:0] t_h;
    logic [2:0][7:0] t_l;
    logic [2:0] hi_f;
    logic [2:0] lo_f;
    logic [2:0] th_f;
    logic [31:0] timer;
    logic pend;
    csl_seq_state_t seq;
    logic [1:0] ch;
    logic start;
    logic req_p;
    logic ack_t;
    logic [7:0] rdata;
  } csl_core_reg_t;
endpackage : csl_pkg

// ===== verilog/csl_sync.sv
module csl_sync #(
  parameter int W = 1 // bits synchronised
) (
  input logic clk, // destination clock
  input logic rst, // async reset
  input logic [W-1:0] d, // foreign input
  output logic [W-1:0] q // synchronised output
);
  typedef struct packed {
    logic [W-1:0] q2;
    logic [W-1:0] q1;
  } csl_sync_reg_t;

  csl_sync_reg_t s_r;
  csl_sync_reg_t s_nxt;

  always_comb begin
    s_nxt.q1 = d;
    s_nxt.q2 = s_r.q1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q2;
endmodule : csl_sync

// ===== verilog/csl_smb_link.sv
`include "csl_map.svh"

module csl_smb_link #(
  parameter logic [6:0] DEV_ADDR = `CSL_SLAVE_ADDR // bus address
) (
  input logic link_clk, // oversampling link clock
  input logic rst, // async reset
  input logic scl_in, // bus clock pin
  input logic sda_in, // bus data pin
  output logic sda_oe, // pull data low
  output logic req_toggle, // access request event
  output csl_pkg::csl_req_t req, // access held stable
  input logic ack_toggle, // core finished access
  input logic [7:0] rdata // read data from core
);
  csl_pkg::csl_link_reg_t s_r;
  csl_pkg::csl_link_reg_t s_nxt;
  logic [2:0] syn_q;
  logic scl_s;
  logic sda_s;
  logic ack_s;
  logic rise;
  logic fall;

  csl_sync #(.W(3)) u_sync (
    .clk(link_clk),
    .rst(rst),
    .d({scl_in, sda_in, ack_toggle}),
    .q(syn_q)
  );

  assign scl_s = syn_q[2];
  assign sda_s = syn_q[1];
  assign ack_s = syn_q[0];
  assign rise = scl_s & ~s_r.scl_p;
  assign fall = ~scl_s & s_r.scl_p;

  // ==========================================
  // byte engine
  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_p = scl_s;
    s_nxt.sda_p = sda_s;
    s_nxt.ack_p = ack_s;
    if (ack_s != s_r.ack_p) begin
      s_nxt.rdata = rdata;
    end
    if (scl_s && s_r.scl_p && s_r.sda_p && !sda_s) begin
      s_nxt.st = csl_pkg::L_ADDR;
      s_nxt.bitc = 3'd0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.first = 1'b1;
      s_nxt.ackon = 1'b0;
    end else if (scl_s && s_r.scl_p && !s_r.sda_p && sda_s) begin
      s_nxt.st = csl_pkg::L_IDLE;
      s_nxt.sda_oe = 1'b0;
    end else begin
      case (s_r.st)
        csl_pkg::L_IDLE: begin
          s_nxt.sda_oe = 1'b0;
        end
        csl_pkg::L_ADDR, csl_pkg::L_WBYTE: begin
          if (rise) begin
            s_nxt.sh = {s_r.sh[6:0], sda_s};
            s_nxt.bitc = s_r.bitc + 3'd1;
            s_nxt.ackon = 1'b0;
            if (s_r.bitc == 3'd7) begin
              s_nxt.st = (s_r.st == csl_pkg::L_ADDR) ? csl_pkg::L_AACK : csl_pkg::L_WACK;
            end
          end
        end
        csl_pkg::L_AACK: begin
          if (fall && !s_r.ackon) begin
            if (s_r.sh[7:1] == DEV_ADDR) begin
              s_nxt.sda_oe = 1'b1;
              s_nxt.ackon = 1'b1;
              s_nxt.rw = s_r.sh[0];
              if (s_r.sh[0]) begin
                s_nxt.req = '{wr: 1'b0, addr: s_r.ptr, wdata: 8'h00};
                s_nxt.req_t = ~s_r.req_t;
              end
            end else begin
              s_nxt.st = csl_pkg::L_IDLE;
            end
          end else if (fall) begin
            s_nxt.ackon = 1'b0;
            s_nxt.bitc = 3'd0;
            s_nxt.sh = s_r.rdata;
            s_nxt.sda_oe = s_r.rw & ~s_r.rdata[7];
            s_nxt.st = s_r.rw ? csl_pkg::L_RBYTE : csl_pkg::L_WBYTE;
          end
        end
        csl_pkg::L_WACK: begin
          if (fall && !s_r.ackon) begin
            s_nxt.sda_oe = 1'b1;
            s_nxt.ackon = 1'b1;
            if (s_r.first) begin
              s_nxt.ptr = s_r.sh;
            end else begin
              s_nxt.req = '{wr: 1'b1, addr: s_r.ptr, wdata: s_r.sh};
              s_nxt.req_t = ~s_r.req_t;
            end
          end else if (fall) begin
            s_nxt.sda_oe = 1'b0;
            s_nxt.ackon = 1'b0;
            s_nxt.first = 1'b0;
            s_nxt.bitc = 3'd0;
            s_nxt.st = csl_pkg::L_WBYTE;
          end
        end
        csl_pkg::L_RBYTE: begin
          if (rise) begin
            s_nxt.bitc = s_r.bitc + 3'd1;
            if (s_r.bitc == 3'd7) begin
              s_nxt.st = csl_pkg::L_RACK;
            end
          end else if (fall) begin
            s_nxt.sda_oe = ~s_r.sh[3'd7 - s_r.bitc];
          end
        end
        csl_pkg::L_RACK: begin
          if (fall && !s_r.ackon) begin
            s_nxt.sda_oe = 1'b0;
          end else if (fall) begin
            s_nxt.ackon = 1'b0;
            s_nxt.bitc = 3'd0;
            s_nxt.sh = s_r.rdata;
            s_nxt.sda_oe = ~s_r.rdata[7];
            s_nxt.st = csl_pkg::L_RBYTE;
          end else if (rise && !sda_s) begin
            s_nxt.ackon = 1'b1;
            s_nxt.req = '{wr: 1'b0, addr: s_r.ptr, wdata: 8'h00};
            s_nxt.req_t = ~s_r.req_t;
          end else if (rise) begin
            s_nxt.st = csl_pkg::L_IDLE;
          end
        end
        default: begin
          s_nxt.st = csl_pkg::L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sda_oe = s_r.sda_oe;
  assign req_toggle = s_r.req_t;
  assign req = s_r.req;
endmodule : csl_smb_link

// ===== verilog/csl_core.sv
`include "csl_map.svh"

// Behaviour
// RULE1 - rate register read 0x04, written 0x0a
// RULE2 - low nibble halves period from 16 s
// RULE3 - code 0x0b converts back to back
// RULE4 - one pass per interval start
// RULE5 - rate register resets to 0x08
// RULE6 - bit 7 disables averaging, slow rates
// RULE7 - host never writes reserved bit 6
// RULE8 - bits 5:4 pick channels or round robin
// RULE9 - high, low, overtemp limits plus hysteresis
// RULE10 - remote high and low limits two bytes
// RULE11 - out of limit sets status flag
// RULE12 - low compare inclusive
// RULE13 - any overtemp drives comparator output low
// RULE14 - shared pin low on high limit exceeded
// RULE15 - hysteresis resets 10, shared, writable
// RULE16 - limits compared raw, never converted
// RULE17 - host rewrites limits after scale change
// RULE18 - overtemp releases below limit minus hysteresis
// RULE19 - extended scale uses +64 offset
// RULE20 - config bit 5 selects second overtemp
// RULE21 - config bit 2 selects extended range
// RULE22 - high compare strictly greater
// RULE23 - single mode leaves other channels alone
module csl_core #(
  parameter logic [31:0] PERIOD0_CYC =
    32'(64'(`CSL_PERIOD0_MS) * 64'd1000000 / 64'(`CSL_CLK_NS)), // code 0 period
  parameter logic [31:0] FAST_CYC =
    32'(64'(`CSL_FAST_US) * 64'd1000 / 64'(`CSL_CLK_NS)), // code 0x0a period
  parameter logic [6:0] DEV_ADDR = `CSL_SLAVE_ADDR // bus address
) (
  input logic clock, // core timebase
  input logic rst, // async power-on reset
  input logic link_clk, // bus oversampling clock
  input logic scl_in, // bus clock pin
  input logic sda_in, // bus data pin level
  output logic sda_out, // bus data drive value
  output logic sda_oe, // bus data drive enable
  output logic conv_start, // start one measurement
  output logic [1:0] conv_ch, // channel to measure
  output logic conv_avg_en, // averaging wanted
  output logic conv_ext_range, // offset binary scale
  input logic conv_done, // measurement ready
  input csl_pkg::csl_meas_t conv_result, // measured value
  output logic busy, // pass in progress
  output logic overtemp_comparator_out_n, // overtemp comparator pin
  output logic shared_pin_n // alert or second overtemp
);
  csl_pkg::csl_core_reg_t s_r;
  csl_pkg::csl_core_reg_t n;
  csl_pkg::csl_req_t req;
  logic req_toggle;
  logic req_s;
  logic req_edge;
  logic lim_hit;
  logic [1:0] lim_ch;
  logic [2:0] lim_fld;
  logic [7:0] rd_val;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [31:0] period;
  logic cont;
  logic last_ch;
  logic [1:0] first_ch;
  logic [9:0] meas10;
  logic [9:0] hi10;
  logic [9:0] lo10;
  logic [7:0] th8;
  logic [8:0] hyst_sum;
  logic alert_any;

  function automatic csl_pkg::csl_core_reg_t core_rst();
    csl_pkg::csl_core_reg_t r;
    r = '0;
    r.cfg = `CSL_CFG_RST;
    r.rate = `CSL_RATE_RST; // RULE5
    r.hyst = `CSL_HYST_RST; // RULE15
    for (int c = 0; c < 3; c++) begin
      r.lim[c][`CSL_LIM_HI_H] = `CSL_HI_RST;
      r.lim[c][`CSL_LIM_LO_H] = `CSL_LO_RST;
      r.lim[c][`CSL_LIM_TH] = `CSL_TH_RST;
    end
    r.seq = csl_pkg::S_WAIT;
    return r;
  endfunction : core_rst

  localparam csl_pkg::csl_core_reg_t CORE_RST = core_rst();

  // ==========================================
  // bus link and crossing
  csl_smb_link #(.DEV_ADDR(DEV_ADDR)) u_link (
    .link_clk(link_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(sda_oe),
    .req_toggle(req_toggle),
    .req(req),
    .ack_toggle(s_r.ack_t),
    .rdata(s_r.rdata)
  );

  csl_sync #(.W(1)) u_req_sync (
    .clk(clock),
    .rst(rst),
    .d(req_toggle),
    .q(req_s)
  );

  assign sda_out = 1'b0;
  assign req_edge = req_s ^ s_r.req_p;
  assign lim_ch = req.addr[4:3];
  assign lim_fld = req.addr[2:0];
  assign lim_hit = (req.addr[7:5] == `CSL_LIM_TAG) && (lim_ch != 2'd3) &&
                   (lim_fld < `CSL_LIM_FLD_N); // RULE9

  // ==========================================
  // read mux
  assign stat1 = {busy, s_r.hi_f[0], s_r.lo_f[0], s_r.hi_f[1], s_r.lo_f[1], 1'b0,
                  s_r.th_f[1], s_r.th_f[0]}; // RULE11
  assign stat2 = {3'b000, s_r.hi_f[2], s_r.lo_f[2], 1'b0, s_r.th_f[2],
                  alert_any & ~s_r.cfg[`CSL_CFG_SHARED]};

  always_comb begin
    rd_val = 8'h00;
    case (req.addr)
      `CSL_A_TEMP_LOC: rd_val = s_r.t_h[0];
      `CSL_A_TEMP_R1H: rd_val = s_r.cfg[`CSL_CFG_R2VIEW] ? s_r.t_h[2] : s_r.t_h[1];
      `CSL_A_TEMP_R1L: rd_val = s_r.cfg[`CSL_CFG_R2VIEW] ? s_r.t_l[2] : s_r.t_l[1];
      `CSL_A_TEMP_R2H: rd_val = s_r.t_h[2];
      `CSL_A_TEMP_R2L: rd_val = s_r.t_l[2];
      `CSL_A_STAT1: rd_val = stat1;
      `CSL_A_STAT2: rd_val = stat2;
      `CSL_A_CFG_RD: rd_val = s_r.cfg;
      `CSL_A_RATE_RD: rd_val = s_r.rate; // RULE1
      `CSL_A_HYST: rd_val = s_r.hyst;
      default: begin
        if (lim_hit) begin
          rd_val = s_r.lim[lim_ch][lim_fld];
        end
      end
    endcase
  end

  // ==========================================
  // schedule and comparison terms
  assign cont = (s_r.rate[3:0] == `CSL_RATE_CONT);
  assign last_ch = (s_r.rate[5:4] != `CSL_SEL_ALL) || (s_r.ch == 2'd2);
  assign first_ch = (s_r.rate[5:4] == `CSL_SEL_ALL) ? 2'd0 : 2'(s_r.rate[5:4] - 2'd1); // RULE8

  always_comb begin
    if (s_r.rate[3:0] >= `CSL_RATE_FAST) begin
      period = FAST_CYC;
    end else begin
      period = PERIOD0_CYC >> s_r.rate[3:0]; // RULE2
    end
  end

  // limits stay raw bytes in whatever scale is active
  always_comb begin
    meas10 = {conv_result.hi, conv_result.lo[7:6]}; // RULE16
    hi10 = {s_r.lim[s_r.ch][`CSL_LIM_HI_H], s_r.lim[s_r.ch][`CSL_LIM_HI_L][7:6]}; // RULE10
    lo10 = {s_r.lim[s_r.ch][`CSL_LIM_LO_H], s_r.lim[s_r.ch][`CSL_LIM_LO_L][7:6]}; // RULE10
    if (s_r.ch == 2'd0) begin
      meas10[1:0] = 2'b00;
      hi10[1:0] = 2'b00;
      lo10[1:0] = 2'b00;
    end
    th8 = s_r.lim[s_r.ch][`CSL_LIM_TH];
    hyst_sum = {1'b0, conv_result.hi} + {1'b0, s_r.hyst};
  end

  // ==========================================
  // next state
  always_comb begin
    n = s_r;
    n.req_p = req_s;
    n.start = 1'b0;
    case (s_r.seq)
      csl_pkg::S_WAIT: begin
        if (s_r.pend || cont) begin // RULE3
          n.pend = 1'b0;
          n.ch = first_ch; // RULE8
          n.seq = csl_pkg::S_START;
        end
      end
      csl_pkg::S_START: begin
        n.start = 1'b1;
        n.seq = csl_pkg::S_CONV;
      end
      csl_pkg::S_CONV: begin
        if (conv_done) begin
          n.t_h[s_r.ch] = conv_result.hi; // RULE23
          n.t_l[s_r.ch] = {meas10[1:0], 6'b000000};
          n.hi_f[s_r.ch] = meas10 > hi10; // RULE22 RULE11
          n.lo_f[s_r.ch] = meas10 <= lo10; // RULE12
          if (conv_result.hi > th8) begin
            n.th_f[s_r.ch] = 1'b1;
          end else if (hyst_sum < {1'b0, th8}) begin
            n.th_f[s_r.ch] = 1'b0; // RULE18
          end
          if (last_ch) begin
            n.seq = csl_pkg::S_WAIT;
          end else begin
            n.ch = s_r.ch + 2'd1;
            n.seq = csl_pkg::S_START;
          end
        end
      end
      default: begin
        n.seq = csl_pkg::S_WAIT;
      end
    endcase
    // interval timer; a new interval wins over consuming the old one
    if (s_r.timer == 32'd0) begin
      n.timer = period - 32'd1; // RULE2
      n.pend = 1'b1; // RULE4
    end else begin
      n.timer = s_r.timer - 32'd1;
    end
    if (req_edge) begin
      if (req.wr) begin
        case (req.addr)
          `CSL_A_CFG_WR: n.cfg = req.wdata; // RULE20 RULE21
          `CSL_A_RATE_WR: begin
            n.rate = req.wdata; // RULE1
            n.timer = 32'd0;
          end
          `CSL_A_HYST: n.hyst = req.wdata; // RULE15
          default: begin
            if (lim_hit) begin
              n.lim[lim_ch][lim_fld] = req.wdata; // RULE9
            end
          end
        endcase
      end else begin
        n.rdata = rd_val;
      end
      n.ack_t = ~s_r.ack_t;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= n;
    end
  end

  // ==========================================
  // outputs
  assign conv_start = s_r.start;
  assign conv_ch = s_r.ch;
  assign conv_avg_en = ~s_r.rate[`CSL_RATE_AVG_DIS] & (s_r.rate[3:0] < `CSL_RATE_NOAVG); // RULE6
  assign conv_ext_range = s_r.cfg[`CSL_CFG_EXT]; // RULE21 RULE19
  assign busy = (s_r.seq != csl_pkg::S_WAIT);
  assign alert_any = ~s_r.cfg[`CSL_CFG_MASK] &
                     (|((s_r.hi_f | s_r.lo_f) &
                        ~{s_r.cfg[`CSL_CFG_MASK_R2], s_r.cfg[`CSL_CFG_MASK_R1], 1'b0}));
  assign overtemp_comparator_out_n = ~(|s_r.th_f); // RULE13
  assign shared_pin_n = s_r.cfg[`CSL_CFG_SHARED] ? ~(|s_r.hi_f) : ~alert_any; // RULE14 RULE20

  // ==========================================
  // checks
  a_rate_write: assert property (@(posedge clock) disable iff (rst) // RULE1
    req_edge && req.wr && (req.addr == `CSL_A_RATE_WR) |=> s_r.rate == $past(req.wdata))
    else $error("rate write not stored");

  a_rate_readback: assert property (@(posedge clock) disable iff (rst) // RULE1
    req_edge && !req.wr && (req.addr == `CSL_A_RATE_RD) |=> s_r.rdata == $past(s_r.rate))
    else $error("rate read returned wrong value");

  a_timer_reload: assert property (@(posedge clock) disable iff (rst) // RULE2
    (s_r.timer == 32'd0) && (s_r.rate[3:0] == 4'h4) && !req_edge
    |=> s_r.timer == (PERIOD0_CYC >> 4) - 32'd1 && s_r.pend)
    else $error("interval reload wrong");

  a_cont_restart: assert property (@(posedge clock) disable iff (rst) // RULE3
    (s_r.seq == csl_pkg::S_CONV) && conv_done && last_ch && cont && !req_edge
    |=> !conv_start ##1 !conv_start ##1 conv_start)
    else $error("continuous mode did not restart");

  a_avg_fast: assert property (@(posedge clock) disable iff (rst) // RULE6
    (s_r.rate[3:0] >= `CSL_RATE_NOAVG) || s_r.rate[`CSL_RATE_AVG_DIS] |-> !conv_avg_en)
    else $error("averaging requested at fast rate");

  a_single_sel: assert property (@(posedge clock) disable iff (rst) // RULE8
    conv_start && (s_r.rate[5:4] == `CSL_SEL_LOC) && $stable(s_r.rate) |-> conv_ch == 2'd0)
    else $error("local only mode measured another channel");

  a_low_incl: assert property (@(posedge clock) disable iff (rst) // RULE12
    (s_r.seq == csl_pkg::S_CONV) && conv_done && (s_r.ch == 2'd0) &&
    (conv_result.hi <= s_r.lim[0][`CSL_LIM_LO_H]) |=> s_r.lo_f[0])
    else $error("low limit not inclusive");

  a_high_equal: assert property (@(posedge clock) disable iff (rst) // RULE22
    (s_r.seq == csl_pkg::S_CONV) && conv_done && (s_r.ch == 2'd0) &&
    (conv_result.hi == s_r.lim[0][`CSL_LIM_HI_H]) |=> !s_r.hi_f[0])
    else $error("equal to high limit flagged");

  a_overtemp_comparator_out_pin: assert property (@(posedge clock) disable iff (rst) // RULE13
    (s_r.seq == csl_pkg::S_CONV) && conv_done &&
    (conv_result.hi > s_r.lim[s_r.ch][`CSL_LIM_TH]) |=> !overtemp_comparator_out_n)
    else $error("overtemp output not asserted");

  a_hyst_hold: assert property (@(posedge clock) disable iff (rst) // RULE18
    (s_r.seq == csl_pkg::S_CONV) && conv_done && (s_r.ch == 2'd0) && s_r.th_f[0] &&
    (hyst_sum >= {1'b0, s_r.lim[0][`CSL_LIM_TH]}) |=> s_r.th_f[0])
    else $error("overtemp released inside hysteresis");

  a_shared_high: assert property (@(posedge clock) disable iff (rst) // RULE14
    s_r.cfg[`CSL_CFG_SHARED] && (s_r.seq == csl_pkg::S_CONV) && conv_done &&
    (meas10 > hi10) && !req_edge |=> !shared_pin_n)
    else $error("second overtemp not asserted");

  a_untouched: assert property (@(posedge clock) disable iff (rst) // RULE23
    (s_r.seq == csl_pkg::S_CONV) && conv_done && (s_r.ch != 2'd0)
    |=> (s_r.t_h[0] == $past(s_r.t_h[0])) && (s_r.lo_f[0] == $past(s_r.lo_f[0])))
    else $error("unselected channel changed");
endmodule : csl_core

// ===== bench/csl_host.sv
`include "csl_map.svh"

// ==========================================
// bus host model, open drain, scl still between frames
module csl_host #(
  parameter logic [6:0] DEV_ADDR = `CSL_SLAVE_ADDR // device address
) (
  output logic scl, // bus clock
  output logic sda_low, // pull data low
  input wire logic sda // resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 1000; // half bit, keeps 1 us low and high

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    #(H/2) sda_low = ~b;
    #(H/2) scl = 1'b1;
    #(H/2) r = sda;
    #(H/2) scl = 1'b0;
  endtask : bit_io

  task automatic start();
    #(H/2) sda_low = 1'b0;
    #(H/2) scl = 1'b1;
    #H sda_low = 1'b1;
    #H scl = 1'b0;
  endtask : start

  task automatic stop();
    #(H/2) sda_low = 1'b1;
    #(H/2) scl = 1'b1;
    #H sda_low = 1'b0;
    #H;
  endtask : stop

  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], b);
      r[i] = b;
    end
    bit_io(last, b);
    ack = ~b;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    xfer(d, 1'b1, r, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, k0);
    xfer(a, 1'b1, r, k1);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r, k2);
    xfer(8'hff, 1'b1, d, k3);
    stop();
    ok = k0 & k1 & k2;
  endtask : rd
endmodule : csl_host

// ===== bench/conversion_scheduler_limit_compare_tb.sv
`include "csl_map.svh"

module conversion_scheduler_limit_compare_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic scl_in = 1'b1;
  logic sda_in = 1'b1;
  logic conv_done = 1'b0;
  csl_pkg::csl_meas_t conv_result = '0;
  csl_pkg::csl_meas_t meas [3];
  logic sda_out, sda_oe, conv_start, conv_avg_en, conv_ext_range, busy;
  logic ovt_n, shr_n, scl_h, sda_low, ok;
  logic [1:0] conv_ch;
  logic [1:0] watch = 2'h0;
  logic [3:0] sh = 4'h0;
  wire logic sda_w;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int n_start = 0;
  int t_last = 0;
  int t_prev = 0;

  assign sda_w = ~sda_low & (sda_oe ? sda_out : 1'b1);
  always #2.5 clock = ~clock;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  csl_core #(.PERIOD0_CYC(32'h0000_8000), .FAST_CYC(32'h0000_0040)) DUT (
    .clock(clock), .rst(rst), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .conv_start(conv_start), .conv_ch(conv_ch),
    .conv_avg_en(conv_avg_en), .conv_ext_range(conv_ext_range), .conv_done(conv_done),
    .conv_result(conv_result), .busy(busy), .overtemp_comparator_out_n(ovt_n),
    .shared_pin_n(shr_n));
  csl_host #(.DEV_ADDR(`CSL_SLAVE_ADDR)) HOST (.scl(scl_h), .sda_low(sda_low), .sda(sda_w));

  // ==========================================
  // measurement source, answers 5 cycles after each start
  always @(posedge clock) begin
    cyc <= cyc + 1;
    scl_in <= scl_h;
    sda_in <= sda_w;
    sh <= {sh[2:0], conv_start};
    conv_done <= sh[3];
    conv_result <= meas[conv_ch];
    if (conv_start === 1'b1 && conv_ch === watch) begin
      n_start <= n_start + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end

  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_starts(input int n);
    int n0 = n_start;
    int k = 0;
    while (n_start < n0 + n && k < 30000) begin
      @(posedge clock);
      k++;
    end
    chk("starts", 16'h1, 16'(n_start >= n0 + n));
  endtask : wait_starts

  task automatic apply(input logic [15:0] m0, input logic [15:0] m1);
    meas[0] <= m0;
    meas[1] <= m1;
    repeat (400) @(posedge clock);
  endtask : apply

  // ==========================================
  // scenarios
  task automatic t_reset();
    chk("avg_en", 16'h1, 16'(conv_avg_en));
    chk("ext", 16'h0, 16'(conv_ext_range));
    repeat (3) @(posedge clock);
    chk("busy", 16'h1, 16'(busy));
    wait_starts(3);
    chk("period", 16'h80, 16'(t_last - t_prev));
  endtask : t_reset

  task automatic t_alert();
    apply(16'h0000, 16'h2000);
    chk("alert_low", 16'h0, 16'(shr_n));
    apply(16'h0100, 16'h2000);
    chk("alert_in", 16'h1, 16'(shr_n));
  endtask : t_alert

  task automatic t_overtemp_comparator_out();
    HOST.wr(`CSL_A_CFG_WR, 8'h24, ok);
    chk("ext", 16'h1, 16'(conv_ext_range));
    apply(16'h5500, 16'h2000);
    chk("hi_eq", 16'h1, 16'(shr_n));
    chk("th_eq", 16'h1, 16'(ovt_n));
    apply(16'h5600, 16'h2000);
    chk("hi_gt", 16'h0, 16'(shr_n));
    chk("th_gt", 16'h0, 16'(ovt_n));
    apply(16'h4b00, 16'h2000);
    chk("th_hold", 16'h0, 16'(ovt_n));
    chk("hi_back", 16'h1, 16'(shr_n));
    apply(16'h4a00, 16'h2000);
    chk("th_rel", 16'h1, 16'(ovt_n));
    HOST.wr(8'h49, 8'h40, ok);
    apply(16'h4a00, 16'h5540);
    chk("r1_eq", 16'h1, 16'(shr_n));
    apply(16'h4a00, 16'h5580);
    chk("r1_gt", 16'h0, 16'(shr_n));
  endtask : t_overtemp_comparator_out

  task automatic t_rate();
    logic [7:0] code [3] = '{8'h94, 8'h2a, 8'h3b};
    int spc [3] = '{2048, 64, 0};
    logic [7:0] rv;
    for (int i = 0; i < 3; i++) begin
      HOST.wr(`CSL_A_RATE_WR, code[i], ok);
      chk("ack", 16'h1, 16'(ok));
      watch = 2'(i);
      wait_starts(3);
      if (spc[i] == 0) begin
        chk("cont", 16'h1, 16'((t_last - t_prev) <= 12));
      end else begin
        chk("period", 16'(spc[i]), 16'(t_last - t_prev));
      end
      chk("avg_en", 16'h0, 16'(conv_avg_en));
    end
    HOST.rd(`CSL_A_RATE_RD, rv, ok);
    chk("rd_ack", 16'h1, 16'(ok));
    chk("rate_rd", 16'h3b, 16'(rv));
  endtask : t_rate

  task automatic test_done();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  initial begin
    meas[0] = 16'h2000;
    meas[1] = 16'h2000;
    meas[2] = 16'h2000;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_alert();
    t_overtemp_comparator_out();
    t_rate();
    test_done();
  end

  initial begin
    #480000;
    error_cnt++;
    test_done();
  end
endmodule : conversion_scheduler_limit_compare_tb
